// >>> rcc_top.sv
// Purpose: Reset and clock control unit: low-power gates, reset causes, reset pin, clock select
// Assumes: APB slave, synchronous active-low reset, pin inputs asynchronous
// Notes:   RST_N is the power reset; other resets leave the cause flags intact
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rcc_top
  import rcc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        BIDIR_RESET_PIN_IN,
  output logic             BIDIR_RESET_PIN_OUT,
  output logic             BIDIR_RESET_PIN_OE,
  input  wire logic        WWDT_EXPIRE,
  input  wire logic        IWDT_EXPIRE,
  input  wire logic        LOW_VOLTAGE,
  input  wire logic        LOCKUP,
  input  wire logic        LPM_RESET,
  input  wire logic        STANDBY_EXIT,
  input  wire logic        STOP_WAKE,
  output logic             SYSTEM_RESET_N,
  output logic [31:0]      RESET_VECTOR_ADDR,
  output logic [1:0]       SYSTEM_CLOCK_SEL,
  output logic [31:0]      APB0_LP_GATES,
  output logic [31:0]      APB1_LP_GATES,
  output logic [31:0]      AHB_LP_GATES,
  output logic             PLL_REF_EXTERNAL,
  output logic [4:0]       PLL_PREDIV,
  output logic [1:0]       PLL_POSTDIV,
  output logic [6:0]       PLL_MUL,
  output logic             PLL_ENABLE,
  output logic             USB_CLOCK_FROM_PLL
);
  import rcc_pkg::*;

  logic [31:0] apb0_lp;
  logic [31:0] apb1_lp;
  logic [31:0] ahb_lp;
  logic [8:0]  cause;
  logic        pll_en;
  logic        pll_sel;
  logic [4:0]  prediv;
  logic [1:0]  postdiv;
  logic [6:0]  mul;
  logic        usb_pll;
  rcc_src_t    clk_src;
  rcc_rst_t    rst_state;
  logic [15:0] stretch_cnt;
  logic        pin_s1;
  logic        pin_s2;
  logic [4:0]  ev_s1;
  logic [4:0]  ev_s2;
  logic [4:0]  ev_prev;
  logic        sw_req;
  logic        wr_en;
  logic [8:0]  next_cause;
  logic [31:0] next_prdata;

  // Address match helper
  // Shared by every write decode below
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: zero wait states
  // Every access completes in its first access cycle; writes land at the
  // access edge, and writes to unmapped words are dropped without error
  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign PREADY  = 1'b1;
  assign PSLVERR = 1'b0;

  // Synchronise pin and event inputs
  // Reset values match the idle level of each pin: the reset pin rests
  // high and events rest low, so no false edge follows a power reset
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      ev_s1  <= 5'h00;
      ev_s2  <= 5'h00;
    end else begin
      pin_s1 <= BIDIR_RESET_PIN_IN;
      pin_s2 <= pin_s1;
      ev_s1  <= {STANDBY_EXIT, LPM_RESET, LOCKUP, IWDT_EXPIRE | STOP_WAKE, WWDT_EXPIRE};
      ev_s2  <= ev_s1;
    end
  end

  // Keep previous synced events for edge detection
  // Only the second sync stage is compared, never the first
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ev_prev <= 5'h00;
    end else begin
      ev_prev <= ev_s2;
    end
  end

  logic lv_s1;
  logic lv_s2;
  logic iw_s1;
  logic iw_s2;
  // Separate level syncs for low voltage and independent watchdog
  // Their own chains keep their cause flags free of stop wake-ups,
  // which share the event chain above with the watchdog
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      lv_s1 <= 1'b0;
      lv_s2 <= 1'b0;
      iw_s1 <= 1'b0;
      iw_s2 <= 1'b0;
    end else begin
      lv_s1 <= LOW_VOLTAGE;
      lv_s2 <= lv_s1;
      iw_s1 <= IWDT_EXPIRE;
      iw_s2 <= iw_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal reset events (pulses)
  // Each event is a rising edge of its synchronised level, one cycle long,
  // so a source that stays asserted raises one reset, not a stream of them.
  // Standby exit, lockup and low-power management share the stretched path.
  logic ev_wwdt;
  logic ev_iwdt;
  logic ev_lock;
  logic ev_lpm;
  logic ev_sbe;
  logic ev_lvr;
  logic ev_wake;
  logic lv_prev;
  logic iw_prev;
  logic ext_low;
  logic internal_req;
  assign ev_wwdt = ev_s2[0] && !ev_prev[0];
  assign ev_wake = ev_s2[1] && !ev_prev[1];
  assign ev_lock = ev_s2[2] && !ev_prev[2];
  assign ev_lpm  = ev_s2[3] && !ev_prev[3];
  assign ev_sbe  = ev_s2[4] && !ev_prev[4];
  assign ev_iwdt = iw_s2 && !iw_prev;
  assign ev_lvr  = lv_s2 && !lv_prev;
  assign ext_low = !pin_s2 && !BIDIR_RESET_PIN_OE;
  // Any internal source starts a stretched reset
  assign internal_req = ev_wwdt | ev_iwdt | sw_req | ev_lvr | ev_lock | ev_lpm | ev_sbe;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      lv_prev <= 1'b0;
      iw_prev <= 1'b0;
    end else begin
      lv_prev <= lv_s2;
      iw_prev <= iw_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset pulse generator: stretch internal, follow external
  // An internal request drives the pin low for the full stretch; once the
  // pin is released the state waits for the synchronised pin to read high,
  // so an outside party still holding the pin extends the reset. A hardware event
  // that arrives while a reset is running only sets its cause flag; a software write is dropped.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rst_state   <= ST_RUN;
      stretch_cnt <= 16'h0000;
    end else begin
      unique case (rst_state)
        ST_RUN: begin
          if (internal_req) begin
            rst_state   <= ST_STRETCH;
            stretch_cnt <= 16'(STRETCH_CYC - 1);
          end else if (ext_low) begin
            rst_state <= ST_EXT_HOLD;
          end
        end
        ST_STRETCH: begin
          if (stretch_cnt == 16'h0000) begin
            rst_state <= ST_EXT_HOLD;
          end else begin
            stretch_cnt <= stretch_cnt - 16'h0001;
          end
        end
        ST_EXT_HOLD: begin
          if (pin_s2) begin
            rst_state <= ST_RUN;
          end
        end
        default: begin
          rst_state <= ST_RUN;                                      // Unused code recovers
        end
      endcase
    end
  end

  // Pin drive and system reset output
  // The pin is only ever pulled low; releasing it hands the level back to
  // the board pull-up and any outside party
  assign BIDIR_RESET_PIN_OUT = 1'b0;
  assign BIDIR_RESET_PIN_OE  = (rst_state == ST_STRETCH);
  assign SYSTEM_RESET_N      = (rst_state == ST_RUN);
  assign RESET_VECTOR_ADDR   = RESET_VECTOR;

  ////////////////////////////////////////////////////////////////////////////
  // Software reset request: write-only, self-clearing
  // The request lives one cycle and is dropped by the reset it starts,
  // so one write can never fire it twice
  always_ff @(posedge CLK) begin
    if (!RST_N || !SYSTEM_RESET_N) begin
      sw_req <= 1'b0;
    end else begin
      sw_req <= wr_en && hit(PADDR, SW_RESET_OFS) && PWDATA[SWRST_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-power clock gate registers; power reset only
  // Reserved bits are masked on write and read back as zero; a system
  // reset leaves the gates alone so software settings survive it
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      apb0_lp <= APB0_LP_RST;
      apb1_lp <= APB1_LP_RST;
      ahb_lp  <= AHB_LP_RST;
    end else if (wr_en) begin
      if (hit(PADDR, APB0_LP_OFS)) apb0_lp <= PWDATA & APB0_LP_MASK;
      if (hit(PADDR, APB1_LP_OFS)) apb1_lp <= PWDATA & APB1_LP_MASK;
      if (hit(PADDR, AHB_LP_OFS))  ahb_lp  <= PWDATA & AHB_LP_MASK;
    end
  end
  assign APB0_LP_GATES = apb0_lp;
  assign APB1_LP_GATES = apb1_lp;
  assign AHB_LP_GATES  = ahb_lp;

  ////////////////////////////////////////////////////////////////////////////
  // Reset-cause flags: set wins over write-one clear
  // A clear that meets a new event in the same cycle keeps the flag, so a
  // cause is never lost; the external flag is only taken in the run state
  // so the tail of an internally driven pin is not blamed on the outside
  always_comb begin
    next_cause = cause;
    if (wr_en && hit(PADDR, RST_CAUSE_OFS)) begin
      next_cause = cause & ~PWDATA[31:CAUSE_LSB];
    end
    // Order: lpm, wwdt, iwdt, lockup, pwr, lvr, sbe, sys, ext
    next_cause = next_cause | {ev_lpm, ev_wwdt, ev_iwdt, ev_lock, 1'b0,
                               ev_lvr, ev_sbe, sw_req,
                               (rst_state == ST_RUN) && ext_low};
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cause <= CAUSE_RST;
    end else begin
      cause <= next_cause;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PLL control: locked while enabled
  // Source and divider fields are frozen while the PLL runs so the analog
  // loop never sees its ratio move; enable and the USB feed stay writable,
  // which lets one write turn the PLL off
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pll_en  <= 1'b0;
      pll_sel <= 1'b0;
      prediv  <= PREDIV_RST;
      postdiv <= POSTDIV_RST;
      mul     <= MUL_RST;
      usb_pll <= 1'b0;
    end else if (wr_en && hit(PADDR, PLL_CTRL_OFS)) begin
      pll_en  <= PWDATA[PLL_EN_BIT];
      usb_pll <= PWDATA[1];
      if (!pll_en) begin
        pll_sel <= PWDATA[PLL_SEL_BIT];
        prediv  <= PWDATA[28:24];
        postdiv <= PWDATA[17:16];
        mul     <= PWDATA[14:8];
      end
    end
  end
  // Divider fields drive the analog PLL, which forms the output ratio
  // USB clock is offered only while the PLL itself runs
  assign PLL_ENABLE         = pll_en;
  assign PLL_REF_EXTERNAL   = pll_sel;
  assign PLL_PREDIV         = prediv;
  assign PLL_POSTDIV        = postdiv;
  assign PLL_MUL            = mul;
  assign USB_CLOCK_FROM_PLL = usb_pll && pll_en;

  ////////////////////////////////////////////////////////////////////////////
  // System clock source; forced to multispeed oscillator on reset or wake
  // Any system reset, standby exit included, lands here as well, so the
  // core always restarts on the slow, always-available source
  always_ff @(posedge CLK) begin
    if (!RST_N || !SYSTEM_RESET_N || ev_wake) begin
      clk_src <= SRC_MULTISPEED;
    end else if (wr_en && hit(PADDR, CLK_SRC_OFS)) begin
      clk_src <= rcc_src_t'(PWDATA[1:0]);
    end
  end
  assign SYSTEM_CLOCK_SEL = clk_src;

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux, registered in the setup phase
  // Registering in setup keeps read data stable through the whole access
  // phase; write-only and unmapped words read as zero
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (PADDR)
      PLL_CTRL_OFS: begin
        next_prdata = {pll_en,                                      // Bit 31
                       2'h0,
                       prediv,                                      // Bits 28:24
                       6'h00,
                       postdiv,                                     // Bits 17:16
                       1'b0,
                       mul,                                         // Bits 14:8
                       6'h00,
                       usb_pll,                                     // Bit 1
                       pll_sel};                                    // Bit 0
      end
      CLK_SRC_OFS:     next_prdata = {30'h0, clk_src};
      APB0_LP_OFS:     next_prdata = apb0_lp;
      APB1_LP_OFS:     next_prdata = apb1_lp;
      AHB_LP_OFS:      next_prdata = ahb_lp;
      RST_CAUSE_OFS:   next_prdata = {cause, 23'h000000};
      default:         next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE) begin
      PRDATA <= next_prdata;
    end
  end
endmodule // rcc_top
`default_nettype wire

// >>> rcc_pkg.sv
// Purpose: Shared constants for the reset and clock control unit
// Assumes: APB register bus, 32-bit data, one clock at 125 MHz
// Notes:   Offsets are byte addresses
`default_nettype none
package rcc_pkg;
  // Register byte offsets
  localparam logic [7:0] PLL_CTRL_OFS    = 8'h00;
  localparam logic [7:0] CLK_SRC_OFS     = 8'h0c;
  localparam logic [7:0] APB0_LP_OFS     = 8'h30;
  localparam logic [7:0] APB1_LP_OFS     = 8'h34;
  localparam logic [7:0] AHB_LP_OFS      = 8'h38;
  localparam logic [7:0] RST_CAUSE_OFS   = 8'h40;
  localparam logic [7:0] SW_RESET_OFS    = 8'h44;
  // Writable bit masks and reset values
  localparam logic [31:0] APB0_LP_MASK  = 32'h1f11_5350;
  localparam logic [31:0] APB0_LP_RST   = 32'h0400_0000;
  localparam logic [31:0] APB1_LP_MASK  = 32'h0231_1050;
  localparam logic [31:0] APB1_LP_RST   = 32'h0000_0000;
  localparam logic [31:0] AHB_LP_MASK   = 32'h0000_9405;
  localparam logic [31:0] AHB_LP_RST    = 32'h0000_0001;
  localparam logic [8:0]  CAUSE_RST     = 9'h010;
  // Field positions
  localparam int CRS_LP_BIT    = 25;
  localparam int IWDT_LP_BIT   = 24;
  localparam int TMR2_LP_BIT   = 20;
  localparam int FLASH_LP_BIT  = 0;
  localparam int CAUSE_LSB     = 23;
  localparam int SWRST_BIT     = 2;
  localparam int PLL_EN_BIT    = 31;
  localparam int PLL_SEL_BIT   = 0;
  // PLL field reset values
  localparam logic [4:0] PREDIV_RST  = 5'h03;
  localparam logic [1:0] POSTDIV_RST = 2'h0;
  localparam logic [6:0] MUL_RST     = 7'h0f;
  // Reset-handler vector address
  localparam logic [31:0] RESET_VECTOR = 32'h0000_0004;
  // Reset stretch timing
  localparam int  CLK_MHZ      = 125;
  localparam int  STRETCH_US   = 20;
  localparam int  STRETCH_CYC  = STRETCH_US * CLK_MHZ;
  // System clock sources and reset pulse states
  typedef enum logic [1:0] {SRC_INT_FAST, SRC_EXT_FAST, SRC_PLL, SRC_MULTISPEED} rcc_src_t;
  typedef enum logic [1:0] {ST_RUN, ST_STRETCH, ST_EXT_HOLD} rcc_rst_t;
endpackage
`default_nettype wire

// >>> rcc_asserts.sv
// Purpose: Port-level checks of the reset and clock control unit
// Assumes: One clock, synchronous active-low power reset
// Notes:   Bound to rcc_top below the module
`timescale 1ns/1ps
`default_nettype none
module rcc_asserts
  import rcc_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        BIDIR_RESET_PIN_IN,
  input wire logic        BIDIR_RESET_PIN_OUT,
  input wire logic        BIDIR_RESET_PIN_OE,
  input wire logic        STOP_WAKE,
  input wire logic        SYSTEM_RESET_N,
  input wire logic [31:0] RESET_VECTOR_ADDR,
  input wire logic [1:0]  SYSTEM_CLOCK_SEL,
  input wire logic [31:0] APB0_LP_GATES,
  input wire logic [31:0] APB1_LP_GATES,
  input wire logic [31:0] AHB_LP_GATES,
  input wire logic        PLL_REF_EXTERNAL,
  input wire logic [4:0]  PLL_PREDIV,
  input wire logic [1:0]  PLL_POSTDIV,
  input wire logic [6:0]  PLL_MUL,
  input wire logic        PLL_ENABLE
);
  logic [12:0] oe_cnt;
  logic        wr;
  logic        rd;
  logic [14:0] pll_fields;
  logic        gates_at_rst;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////
  // Access qualifiers: write access phase, read setup phase
  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && !PENABLE && !PWRITE;
  // Frozen PLL fields and gate reset values
  assign pll_fields   = {PLL_PREDIV, PLL_POSTDIV, PLL_MUL, PLL_REF_EXTERNAL};
  assign gates_at_rst = AHB_LP_GATES == 32'h1 && APB1_LP_GATES == 32'h0 && APB0_LP_GATES == 32'h0400_0000;
  // Length of the current pin-drive stretch, saturating
  always_ff @(posedge CLK) begin
    if (!RST_N || !BIDIR_RESET_PIN_OE) begin
      oe_cnt <= 13'h0;
    end else if (oe_cnt != 13'h1fff) begin
      oe_cnt <= oe_cnt + 13'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  AST_VECTOR: assert property (RESET_VECTOR_ADDR == 32'h0000_0004)
    else $error("reset vector address wrong");
  AST_SWREQ: assert property (wr && PADDR == SW_RESET_OFS && PWDATA[2] |-> ##[1:4] !SYSTEM_RESET_N)
    else $error("software request gave no system reset");
  AST_STRETCH: assert property ($fell(BIDIR_RESET_PIN_OE) |-> oe_cnt >= STRETCH_CYC)
    else $error("internal reset stretch too short");
  AST_PIN_LOW: assert property (BIDIR_RESET_PIN_OE |-> !BIDIR_RESET_PIN_OUT && !SYSTEM_RESET_N)
    else $error("pin driven without system reset low");
  AST_EXT_HOLD: assert property (!BIDIR_RESET_PIN_IN [*5] |-> !SYSTEM_RESET_N)
    else $error("system reset high while pin held low");
  AST_PLL_LOCK: assert property (PLL_ENABLE && $past(PLL_ENABLE) |-> $stable(pll_fields))
    else $error("pll fields changed while enabled");
  AST_WAKE_CLK_SRC: assert property ($rose(STOP_WAKE) |-> ##[1:8] SYSTEM_CLOCK_SEL == SRC_MULTISPEED)
    else $error("wake did not select multispeed source");
  AST_CAUSE_LOW: assert property (rd && PADDR == RST_CAUSE_OFS |=> PRDATA[22:0] == 23'h0)
    else $error("cause register low bits not zero");
  AST_SWREG_RD: assert property (rd && PADDR == SW_RESET_OFS |=> PRDATA == 32'h0)
    else $error("write-only register read back nonzero");
  AST_GATE_RST: assert property ($rose(RST_N) |-> gates_at_rst)
    else $error("gate reset values wrong");
  // Main scenarios reached
  cover property ($fell(BIDIR_RESET_PIN_OE));
  cover property ($rose(STOP_WAKE));
  cover property (PLL_ENABLE && wr && PADDR == PLL_CTRL_OFS);
endmodule // rcc_asserts
bind rcc_top rcc_asserts chk_u (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
  .BIDIR_RESET_PIN_IN, .BIDIR_RESET_PIN_OUT, .BIDIR_RESET_PIN_OE, .STOP_WAKE, .SYSTEM_RESET_N,
  .RESET_VECTOR_ADDR, .SYSTEM_CLOCK_SEL, .APB0_LP_GATES, .APB1_LP_GATES, .AHB_LP_GATES,
  .PLL_REF_EXTERNAL, .PLL_PREDIV, .PLL_POSTDIV, .PLL_MUL, .PLL_ENABLE);
`default_nettype wire

// >>> rcc_pin_model.sv
// Purpose: Reset pin wire with pull-up, shared by the block and an outside party
// Assumes: Open-drain pin, low means reset
// Notes:   Reads high when nobody pulls it low
`timescale 1ns/1ps
`default_nettype none
module rcc_pin_model (
  input  wire logic pin_out,
  input  wire logic pin_oe,
  input  wire logic ext_low,
  output logic      pin_in
);
  // Wired-low level; outside party holds it low as long as asked
  assign pin_in = !((pin_oe && !pin_out) || ext_low);
endmodule // rcc_pin_model
`default_nettype wire

// >>> reset_and_clock_control_unit_tb.sv
// Purpose: Self-checking bench for the reset and clock control unit
// Assumes: APB master with NBA drive at rising edges
// Notes:   Port values are sampled at the falling edge after writes and after the wake pulse, at rising edges elsewhere
`timescale 1ns/1ps
`default_nettype none
module reset_and_clock_control_unit_tb;
  import rcc_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        stop_wake, ext_low, pin_in, pin_out, pin_oe, sys_rst_n;
  logic        ref_ext, pll_en, usb_pll;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, vec, g0, g1, g2, q;
  logic [5:0]  ev;
  logic [1:0]  csel, post;
  logic [4:0]  pre;
  logic [6:0]  mul;
  int          errors, samples_checked, cyc;
  rcc_top dut_u (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .BIDIR_RESET_PIN_IN(pin_in), .BIDIR_RESET_PIN_OUT(pin_out), .BIDIR_RESET_PIN_OE(pin_oe),
    .WWDT_EXPIRE(ev[0]), .IWDT_EXPIRE(ev[1]), .LOW_VOLTAGE(ev[2]), .LOCKUP(ev[3]),
    .LPM_RESET(ev[4]), .STANDBY_EXIT(ev[5]), .STOP_WAKE(stop_wake), .SYSTEM_RESET_N(sys_rst_n),
    .RESET_VECTOR_ADDR(vec), .SYSTEM_CLOCK_SEL(csel), .APB0_LP_GATES(g0), .APB1_LP_GATES(g1),
    .AHB_LP_GATES(g2), .PLL_REF_EXTERNAL(ref_ext), .PLL_PREDIV(pre), .PLL_POSTDIV(post),
    .PLL_MUL(mul), .PLL_ENABLE(pll_en), .USB_CLOCK_FROM_PLL(usb_pll));
  rcc_pin_model pin_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_low(ext_low), .pin_in(pin_in));
  ////////////////////////////////////////////////////////////
  // 125 MHz clock and run watchdog
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      finish_test;
    end
  end
  ////////////////////////////////////////////////////////////
  task finish_test;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer; read data taken at the completing edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("prdata", q, e);
  endtask
  task wait_sys(output logic low);
    low = 1'b0;
    repeat (20) begin
      @(posedge clk);
      if (sys_rst_n === 1'b0) low = 1'b1;
    end
    while (sys_rst_n !== 1'b1) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////
  task t_reset;
    rchk(APB0_LP_OFS, 32'h0400_0000);
    rchk(APB1_LP_OFS, 32'h0);
    rchk(AHB_LP_OFS, 32'h1);
    rchk(RST_CAUSE_OFS, 32'h0800_0000);
    rchk(8'h50, 32'h0);
    chk("clksel", csel, 32'h3);
    chk("vector", vec, 32'h0000_0004);
    chk("pll", {pre, mul, ref_ext}, {5'h03, 7'h0f, 1'b0});
    $display("test reset done");
  endtask
  task t_gates;
    logic [7:0]  ofs [3];
    logic [31:0] msk [3];
    ofs = '{APB0_LP_OFS, APB1_LP_OFS, AHB_LP_OFS};
    msk = '{APB0_LP_MASK, APB1_LP_MASK, AHB_LP_MASK};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ofs[i], 32'hffff_ffff);
      rchk(ofs[i], msk[i]);
      apb(1'b1, ofs[i], 32'h0);
      rchk(ofs[i], 32'h0);
    end
    apb(1'b1, APB1_LP_OFS, 32'h0200_0000);
    apb(1'b1, APB0_LP_OFS, 32'h0110_0000);
    @(negedge clk);
    chk("apb0 gates", g0, 32'h0110_0000);
    chk("apb1 gates", g1, 32'h0200_0000);
    chk("ahb gates", g2, 32'h0);
    $display("test gates done");
  endtask
  task t_w1c;
    apb(1'b1, RST_CAUSE_OFS, 32'h0);
    rchk(RST_CAUSE_OFS, 32'h0800_0000);
    apb(1'b1, RST_CAUSE_OFS, 32'h0800_0000);
    rchk(RST_CAUSE_OFS, 32'h0);
    $display("test w1c done");
  endtask
  task t_swrst;
    int n;
    n = 0;
    apb(1'b1, SW_RESET_OFS, 32'h4);
    while (sys_rst_n !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk("swrst", sys_rst_n, 1'b0);
    n = 0;
    while (sys_rst_n === 1'b0) begin
      @(posedge clk);
      n++;
    end
    chk("stretch", n >= 2500, 1'b1);
    rchk(RST_CAUSE_OFS, 32'h0100_0000);
    rchk(SW_RESET_OFS, 32'h0);
    apb(1'b1, RST_CAUSE_OFS, 32'hff80_0000);
    $display("test software reset done");
  endtask
  task t_events;
    int   b [6];
    logic low;
    b = '{30, 29, 26, 28, 31, 25};
    for (int i = 0; i < 6; i++) begin
      ev[i] <= 1'b1;
      repeat (4) @(posedge clk);
      ev[i] <= 1'b0;
      wait_sys(low);
      chk("event reset", low, 1'b1);
      rchk(RST_CAUSE_OFS, 32'h1 << b[i]);
      apb(1'b1, RST_CAUSE_OFS, 32'hff80_0000);
    end
    $display("test events done");
  endtask
  task t_ext;
    ext_low <= 1'b1;
    repeat (100) @(posedge clk);
    chk("ext hold", sys_rst_n, 1'b0);
    ext_low <= 1'b0;
    repeat (8) @(posedge clk);
    chk("ext end", sys_rst_n, 1'b1);
    rchk(RST_CAUSE_OFS, 32'h0080_0000);
    apb(1'b1, RST_CAUSE_OFS, 32'h0080_0000);
    $display("test external reset done");
  endtask
  task t_pll;
    apb(1'b1, PLL_CTRL_OFS, 32'h0102_1703); // 16 MHz source: 8 MHz reference, 192 MHz VCO
    @(negedge clk);
    chk("pll", {pre, post, mul, ref_ext, usb_pll}, {5'h01, 2'h2, 7'h17, 2'h2});
    apb(1'b1, PLL_CTRL_OFS, 32'h8102_1703);
    @(negedge clk);
    chk("usb", usb_pll, 1'b1);
    apb(1'b1, PLL_CTRL_OFS, 32'h9e03_3e00);
    @(negedge clk);
    chk("lock", {pll_en, pre, post, mul, ref_ext}, {1'b1, 5'h01, 2'h2, 7'h17, 1'b1});
    apb(1'b1, PLL_CTRL_OFS, 32'h0);
    @(negedge clk);
    chk("pll off", pll_en, 1'b0);
    $display("test pll done");
  endtask
  task t_clk;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CLK_SRC_OFS, i);
      @(negedge clk);
      chk("clksel", csel, i);
    end
    apb(1'b1, CLK_SRC_OFS, 32'h1);
    stop_wake <= 1'b1;
    repeat (8) @(posedge clk);
    stop_wake <= 1'b0;
    @(negedge clk);
    chk("wake", csel, 32'h3);
    $display("test clock select done");
  endtask
  task t_por;
    apb(1'b1, APB1_LP_OFS, 32'hffff_ffff);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rchk(APB1_LP_OFS, 32'h0);
    rchk(RST_CAUSE_OFS, 32'h0800_0000);
    $display("test power reset done");
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, stop_wake, ext_low} = 6'h0;
    {paddr, pwdata, ev} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_gates;
    t_w1c;
    t_swrst;
    t_events;
    t_ext;
    t_pll;
    t_clk;
    t_por;
    finish_test;
  end
endmodule // reset_and_clock_control_unit_tb
`default_nettype wire
